// [hdl/sd_init_params.svh]
`ifndef SD_INIT_PARAMS_SVH
`define SD_INIT_PARAMS_SVH

// clocks and timing
`define MCLK_MHZ 125
`define POWERUP_TIME_US 1000
`define POWERUP_CYCLES (`POWERUP_TIME_US * `MCLK_MHZ)
`define PU_CNT_W 32
`define RESP_GAP 2'h2

// frame lengths in link clocks
`define FRAME_LEN 6'h30
`define SHORT_RESP_LEN 8'h30
`define LONG_RESP_LEN 8'h88
`define CRC_FIRST 8'h08
`define CRC_LAST 8'h02
`define CRC_COVER 6'h28
`define CRC7_POLY 7'h09
`define CRC_FILL 7'h7f

// command indices
`define CMD_GO_IDLE 6'h00
`define CMD_SEND_ID 6'h02
`define CMD_SEND_ADDR 6'h03
`define CMD_SET_DRIVER 6'h04
`define CMD_IF_COND 6'h08
`define CMD_APP 6'h37
`define CMD_OP_COND 6'h29
`define LONG_INDEX 6'h3f

// operating-conditions layout
`define OCR_READY_BIT 31
`define OCR_CAP_BIT 30
`define OCR_S18_BIT 24
`define OCR_LOW_V_BIT 7
`define OCR_WIN_HI 23
`define OCR_WIN_LO 15
`define OCR_WINDOW 9'h1ff
`define HCS_ARG_BIT 30
`define IF_VOLT 4'h1

// card status word
`define CS_STATE_HI 12
`define CS_STATE_LO 9
`define CS_APP_BIT 5
`define ST_CODE_IDLE 4'h0
`define ST_CODE_READY 4'h1
`define ST_CODE_IDENT 4'h2
`define ST_CODE_STBY 4'h3
`define ST_CODE_INACT 4'hf

// reset values
`define ADDR_RESET 16'h0000
`define DRIVER_RESET 16'h0404
`define LFSR_SEED 16'hace1
`define LFSR_TAPS 16'hb400

`endif

// [hdl/sd_init_pkg.sv]
`include "sd_init_params.svh"

package sd_init_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_ready,
		st_ident,
		st_stby,
		st_inactive
	} card_state_t;

	// snapshot handed from the link side to the system side
	typedef struct packed {
		logic [3:0] state;
		logic inactive;
		logic [15:0] relative_card_address;
		logic [15:0] dsr;
	} card_view_t;

	typedef struct packed {
		card_state_t state;
		logic [5:0] rx_cnt;
		logic [47:0] rx_sr;
		logic [6:0] rx_crc;
		logic [135:0] tx_sr;
		logic [7:0] tx_cnt;
		logic [1:0] tx_wait;
		logic [6:0] tx_crc;
		logic tx_use_crc;
		logic cmd_out;
		logic cmd_oe;
		logic app_cmd;
		logic cmd8_seen;
		logic acmd41_seen;
		logic hold_busy;
		logic pu_s1;
		logic pu_s2;
		logic [15:0] relative_card_address;
		logic [15:0] dsr;
		logic [15:0] lfsr;
		card_view_t hold;
		logic req;
		logic ack_s1;
		logic ack_s2;
	} link_regs_t;

	typedef struct packed {
		logic [`PU_CNT_W-1:0] pu_cnt;
		logic pu_done;
		logic req_s1;
		logic req_s2;
		logic req_s3;
		card_view_t view;
	} sys_regs_t;

endpackage : sd_init_pkg

// [hdl/sd_card_init_identification.sv]
`include "sd_init_params.svh"

module sd_card_init_identification #(
	parameter int POWERUP_CYCLES = `POWERUP_CYCLES,
	parameter logic HIGH_CAPACITY = 1'b1,
	parameter logic DUAL_VOLTAGE = 1'b1,
	// identity value is arbitrary; crc and fixed bits are filled in
	parameter logic [127:0] CARD_ID = 128'h5a_1234_4142434445_10_00000001_0_000_00,
	parameter logic [511:0] EXT_STATUS = 512'h0
) (
	// system clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// command line, on the host's clock
	input wire logic sd_clk,
	input wire logic cmd_in,
	output logic cmd_out,
	output logic cmd_oe,
	// card view, system clock domain
	output logic powerup_done,
	output logic [3:0] card_state,
	output logic card_inactive,
	output logic [15:0] card_rca,
	output logic [15:0] card_dsr,
	output logic [511:0] ext_status_block
);

	sd_init_pkg::link_regs_t l_r;
	sd_init_pkg::link_regs_t l_next;
	sd_init_pkg::sys_regs_t s_r;
	sd_init_pkg::sys_regs_t s_next;

	function automatic logic [6:0] crc7_step(input logic [6:0] c,
		input logic b);
		logic fb;
		fb = b ^ c[6];
		crc7_step = {c[5:0], 1'b0} ^ (fb ? `CRC7_POLY : 7'h00);
	endfunction : crc7_step

	function automatic logic [15:0] lfsr_step(input logic [15:0] v);
		lfsr_step = {1'b0, v[15:1]} ^ (v[0] ? `LFSR_TAPS : 16'h0000);
	endfunction : lfsr_step

	function automatic logic [3:0] state_code(
		input sd_init_pkg::card_state_t s);
		case (s)
			sd_init_pkg::st_idle: state_code = `ST_CODE_IDLE;
			sd_init_pkg::st_ready: state_code = `ST_CODE_READY;
			sd_init_pkg::st_ident: state_code = `ST_CODE_IDENT;
			sd_init_pkg::st_stby: state_code = `ST_CODE_STBY;
			default: state_code = `ST_CODE_INACT;
		endcase
	endfunction : state_code

	// status word: only state and app flag live here, rest reserved 0
	function automatic logic [31:0] status_word(
		input sd_init_pkg::card_state_t s, input logic app);
		status_word = 32'h0000_0000;
		status_word[`CS_STATE_HI:`CS_STATE_LO] = state_code(s);
		status_word[`CS_APP_BIT] = app;
	endfunction : status_word

	// identity word with reserved nibble cleared, crc and stop bit fixed
	function automatic logic [127:0] id_word(input logic [127:0] raw);
		logic [127:0] w;
		logic [6:0] c;
		w = raw;
		w[23:20] = 4'h0;
		c = 7'h00;
		for (int i = 127; i >= 8; i--)
		begin
			c = crc7_step(c, w[i]);
		end
		w[7:1] = c;
		w[0] = 1'b1;
		id_word = w;
	endfunction : id_word

	// link side working signals
	logic [47:0] frame;
	logic [5:0] cmd_idx;
	logic [31:0] cmd_arg;
	logic frame_ok;
	logic tx_bit;
	logic tx_active;
	logic busy_now;
	logic ready_now;
	logic [31:0] operating_conditions;
	logic [15:0] addr_new;
	sd_init_pkg::card_view_t view_now;

	always_comb
	begin
		l_next = l_r;
		frame = {l_r.rx_sr[46:0], cmd_in};
		cmd_idx = frame[45:40];
		cmd_arg = frame[39:8];
		frame_ok = 1'b0;
		tx_bit = 1'b1;
		tx_active = (l_r.tx_wait == 2'h0) && (l_r.tx_cnt != 8'h00);
		busy_now = l_r.hold_busy;
		ready_now = 1'b0;
		operating_conditions = 32'h0000_0000;
		addr_new = l_r.lfsr;
		view_now = '0;

		// power-up level from the system side
		l_next.pu_s1 = s_r.pu_done;
		l_next.pu_s2 = l_r.pu_s1;
		l_next.ack_s1 = s_r.req_s3;
		l_next.ack_s2 = l_r.ack_s1;
		l_next.lfsr = lfsr_step(l_r.lfsr);
		l_next.cmd_oe = 1'b0;
		l_next.cmd_out = 1'b1;

		// response: wait the gap, then shift out msb first
		if (l_r.tx_wait != 2'h0)
		begin
			l_next.tx_wait = l_r.tx_wait - 2'h1;
		end
		else if (tx_active)
		begin
			if (l_r.tx_use_crc && (l_r.tx_cnt <= `CRC_FIRST) &&
				(l_r.tx_cnt >= `CRC_LAST))
			begin
				tx_bit = l_r.tx_crc[6];
				l_next.tx_crc = {l_r.tx_crc[5:0], 1'b0};
			end
			else
			begin
				tx_bit = l_r.tx_sr[135];
				if (l_r.tx_cnt > `CRC_FIRST)
				begin
					l_next.tx_crc = crc7_step(l_r.tx_crc, tx_bit);
				end
			end
			l_next.tx_sr = {l_r.tx_sr[134:0], 1'b0};
			l_next.tx_cnt = l_r.tx_cnt - 8'h01;
			l_next.cmd_out = tx_bit;
			l_next.cmd_oe = 1'b1;
		end
		// the line is ours while answering, so receive only when quiet
		else if (l_r.rx_cnt == 6'h00)
		begin
			if (!cmd_in)
			begin
				l_next.rx_cnt = 6'h01;
				l_next.rx_sr = 48'h0;
				l_next.rx_crc = crc7_step(7'h00, 1'b0);
			end
		end
		else
		begin
			l_next.rx_sr = frame;
			l_next.rx_cnt = l_r.rx_cnt + 6'h01;
			if (l_r.rx_cnt < `CRC_COVER)
			begin
				l_next.rx_crc = crc7_step(l_r.rx_crc, cmd_in);
			end
			if (l_r.rx_cnt == `FRAME_LEN - 6'h01)
			begin
				l_next.rx_cnt = 6'h00;
				frame_ok = frame[46] && frame[0] &&
					(frame[7:1] == l_r.rx_crc);
			end
		end

		// bad crc or direction is silently dropped, as a real card does
		if (frame_ok && (l_r.state != sd_init_pkg::st_inactive))
		begin
			l_next.app_cmd = 1'b0;
			case (cmd_idx)
				`CMD_GO_IDLE:
				begin
					l_next.state = sd_init_pkg::st_idle;
					l_next.cmd8_seen = 1'b0;
					l_next.acmd41_seen = 1'b0;
					l_next.hold_busy = 1'b0;
					l_next.relative_card_address = `ADDR_RESET;
				end
				`CMD_IF_COND:
				begin
					if ((l_r.state == sd_init_pkg::st_idle) &&
						(cmd_arg[11:8] == `IF_VOLT))
					begin
						l_next.cmd8_seen = 1'b1;
						l_next.tx_sr = {2'b00, `CMD_IF_COND, 20'h00000,
							`IF_VOLT, cmd_arg[7:0], `CRC_FILL, 1'b1,
							88'h0};
						l_next.tx_cnt = `SHORT_RESP_LEN;
						l_next.tx_wait = `RESP_GAP;
						l_next.tx_crc = 7'h00;
						l_next.tx_use_crc = 1'b1;
					end
				end
				`CMD_APP:
				begin
					l_next.app_cmd = 1'b1;
					l_next.tx_sr = {2'b00, `CMD_APP,
						status_word(l_r.state, 1'b1), `CRC_FILL, 1'b1,
						88'h0};
					l_next.tx_cnt = `SHORT_RESP_LEN;
					l_next.tx_wait = `RESP_GAP;
					l_next.tx_crc = 7'h00;
					l_next.tx_use_crc = 1'b1;
				end
				`CMD_OP_COND:
				begin
					if (l_r.app_cmd && (l_r.state == sd_init_pkg::st_idle))
					begin
						if (!l_r.acmd41_seen)
						begin
							l_next.acmd41_seen = 1'b1;
							// flag counts only after CMD8 was answered
							busy_now = HIGH_CAPACITY &&
								!(cmd_arg[`HCS_ARG_BIT] &&
								l_r.cmd8_seen);
							l_next.hold_busy = busy_now;
						end
						ready_now = l_r.pu_s2 && !busy_now;
						operating_conditions[`OCR_READY_BIT] = ready_now;
						operating_conditions[`OCR_CAP_BIT] = ready_now &&
							l_r.cmd8_seen && HIGH_CAPACITY;
						operating_conditions[`OCR_S18_BIT] = 1'b0;
						operating_conditions[`OCR_WIN_HI:`OCR_WIN_LO] = `OCR_WINDOW;
						operating_conditions[`OCR_LOW_V_BIT] = DUAL_VOLTAGE &&
							l_r.cmd8_seen;
						if (!l_r.acmd41_seen && ((cmd_arg[`OCR_WIN_HI:
							`OCR_WIN_LO] & `OCR_WINDOW) == 9'h000))
						begin
							l_next.state = sd_init_pkg::st_inactive;
						end
						else
						begin
							if (ready_now)
							begin
								l_next.state = sd_init_pkg::st_ready;
							end
							l_next.tx_sr = {2'b00, `LONG_INDEX, operating_conditions,
								`CRC_FILL, 1'b1, 88'h0};
							l_next.tx_cnt = `SHORT_RESP_LEN;
							l_next.tx_wait = `RESP_GAP;
							l_next.tx_use_crc = 1'b0;
						end
					end
				end
				`CMD_SEND_ID:
				begin
					if (l_r.state == sd_init_pkg::st_ready)
					begin
						l_next.tx_sr = {2'b00, `LONG_INDEX,
							id_word(CARD_ID)};
						l_next.tx_cnt = `LONG_RESP_LEN;
						l_next.tx_wait = `RESP_GAP;
						l_next.tx_use_crc = 1'b0;
						l_next.state = sd_init_pkg::st_ident;
					end
				end
				`CMD_SEND_ADDR:
				begin
					if ((l_r.state == sd_init_pkg::st_ident) ||
						(l_r.state == sd_init_pkg::st_stby))
					begin
						// the generator never yields zero; skip a repeat
						if (addr_new == l_r.relative_card_address)
						begin
							addr_new = lfsr_step(l_r.lfsr);
						end
						l_next.relative_card_address = addr_new;
						l_next.state = sd_init_pkg::st_stby;
						l_next.tx_sr = {2'b00, `CMD_SEND_ADDR, addr_new,
							3'b000, state_code(l_r.state), 9'h000,
							`CRC_FILL, 1'b1, 88'h0};
						l_next.tx_cnt = `SHORT_RESP_LEN;
						l_next.tx_wait = `RESP_GAP;
						l_next.tx_crc = 7'h00;
						l_next.tx_use_crc = 1'b1;
					end
				end
				`CMD_SET_DRIVER:
				begin
					// broadcast, no answer on the line
					if (l_r.state == sd_init_pkg::st_stby)
					begin
						l_next.dsr = cmd_arg[31:16];
					end
				end
				default:
				begin
					l_next.app_cmd = 1'b0;
				end
			endcase
		end

		// hand a new view over only once the last one was acknowledged
		view_now.state = state_code(l_next.state);
		view_now.inactive = (l_next.state == sd_init_pkg::st_inactive);
		view_now.relative_card_address = l_next.relative_card_address;
		view_now.dsr = l_next.dsr;
		if ((view_now != l_r.hold) && (l_r.ack_s2 == l_r.req))
		begin
			l_next.hold = view_now;
			l_next.req = ~l_r.req;
		end
	end

	always_ff @(posedge sd_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			l_r <= '0;
			l_r.state <= sd_init_pkg::st_idle;
			l_r.cmd_out <= 1'b1;
			l_r.relative_card_address <= `ADDR_RESET;
			l_r.dsr <= `DRIVER_RESET;
			l_r.lfsr <= `LFSR_SEED;
			l_r.hold.state <= `ST_CODE_IDLE;
			l_r.hold.relative_card_address <= `ADDR_RESET;
			l_r.hold.dsr <= `DRIVER_RESET;
		end
		else
		begin
			l_r <= l_next;
		end
	end

	// system side: power-up timer and the view capture
	always_comb
	begin
		s_next = s_r;
		s_next.req_s1 = l_r.req;
		s_next.req_s2 = s_r.req_s1;
		s_next.req_s3 = s_r.req_s2;
		if (s_r.req_s2 != s_r.req_s3)
		begin
			s_next.view = l_r.hold;
		end
		if (!s_r.pu_done)
		begin
			if (s_r.pu_cnt == `PU_CNT_W'(POWERUP_CYCLES - 1))
			begin
				s_next.pu_done = 1'b1;
			end
			else
			begin
				s_next.pu_cnt = s_r.pu_cnt + `PU_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_r <= '0;
			s_r.view.state <= `ST_CODE_IDLE;
			s_r.view.relative_card_address <= `ADDR_RESET;
			s_r.view.dsr <= `DRIVER_RESET;
		end
		else
		begin
			s_r <= s_next;
		end
	end

	assign cmd_out = l_r.cmd_out;
	assign cmd_oe = l_r.cmd_oe;
	assign powerup_done = s_r.pu_done;
	assign card_state = s_r.view.state;
	assign card_inactive = s_r.view.inactive;
	assign card_rca = s_r.view.relative_card_address;
	assign card_dsr = s_r.view.dsr;
	// status block is factory content, read only
	assign ext_status_block = EXT_STATUS;

endmodule : sd_card_init_identification

// [sim/sd_init_checker_asserts.sv]
module sd_init_checker #(
	parameter int POWERUP_CYCLES = 20
) (
	// clocks and reset
	input wire logic mclk,
	input wire logic sd_clk,
	input wire logic rstn,
	// command line
	input wire logic cmd_out,
	input wire logic cmd_oe,
	// card view
	input wire logic powerup_done,
	input wire logic [3:0] card_state,
	input wire logic card_inactive,
	input wire logic [15:0] card_rca,
	input wire logic [15:0] card_dsr
);
	logic [31:0] pu_cyc;
	logic [7:0] oe_cnt;
	// saturates, so a stuck flag cannot wrap into a match
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			pu_cyc <= 32'h0;
		else if (pu_cyc != 32'hffffffff)
			pu_cyc <= pu_cyc + 32'h1;
	always_ff @(posedge sd_clk or negedge rstn)
		if (!rstn)
			oe_cnt <= 8'h00;
		else
			oe_cnt <= cmd_oe ? oe_cnt + 8'h01 : 8'h00;
	a_state_legal: assert property (
		@(posedge mclk) disable iff (!rstn)
		card_state inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hf})
		else $error("state code out of range");
	a_inactive_match: assert property (
		@(posedge mclk) disable iff (!rstn)
		card_inactive == (card_state == 4'hf))
		else $error("inactive flag disagrees with state");
	a_inactive_sticky: assert property (
		@(posedge mclk) disable iff (!rstn)
		card_inactive |=> card_inactive)
		else $error("inactive left without reset");
	a_ready_after_pu: assert property (
		@(posedge mclk) disable iff (!rstn)
		card_state == 4'h1 |-> powerup_done)
		else $error("ready before power-up done");
	a_pu_timing: assert property (
		@(posedge mclk) disable iff (!rstn)
		$rose(powerup_done) |-> pu_cyc >= POWERUP_CYCLES - 1 &&
		pu_cyc <= POWERUP_CYCLES + 3)
		else $error("power-up done at wrong time");
	a_ident_from_ready: assert property (
		@(posedge mclk) disable iff (!rstn)
		$changed(card_state) && card_state == 4'h2 |->
		$past(card_state) == 4'h1)
		else $error("identification entered not from ready");
	a_stby_has_rca: assert property (
		@(posedge mclk) disable iff (!rstn)
		card_state == 4'h3 |-> card_rca != 16'h0000)
		else $error("stand-by with zero address");
	a_rca_in_stby: assert property (
		@(posedge mclk) disable iff (!rstn)
		$changed(card_rca) && card_rca != 16'h0000 |-> card_state == 4'h3)
		else $error("address changed outside stand-by");
	a_dsr_only_stby: assert property (
		@(posedge mclk) disable iff (!rstn)
		$changed(card_dsr) |-> $past(card_state) == 4'h3)
		else $error("driver stage changed outside stand-by");
	a_resp_length: assert property (
		@(posedge sd_clk) disable iff (!rstn)
		$fell(cmd_oe) |-> oe_cnt == 8'h30 || oe_cnt == 8'h88)
		else $error("response length wrong");
	a_resp_start: assert property (
		@(posedge sd_clk) disable iff (!rstn)
		$rose(cmd_oe) |-> !cmd_out)
		else $error("response start bit not low");
endmodule : sd_init_checker

bind sd_card_init_identification sd_init_checker #(
	.POWERUP_CYCLES(POWERUP_CYCLES)
) sd_init_checker_i (
	.mclk(mclk),
	.sd_clk(sd_clk),
	.rstn(rstn),
	.cmd_out(cmd_out),
	.cmd_oe(cmd_oe),
	.powerup_done(powerup_done),
	.card_state(card_state),
	.card_inactive(card_inactive),
	.card_rca(card_rca),
	.card_dsr(card_dsr)
);

// [sim/sd_host_model.sv]
module sd_host_model (
	// link clock and command wire
	output logic sd_clk,
	output wire logic cmd_line,
	input wire logic cmd_out,
	input wire logic cmd_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run = 1'b0;
	logic drv = 1'b0;
	logic dq = 1'b1;
	// pull-up holds the line high when nobody drives
	assign cmd_line = cmd_oe ? cmd_out : (drv ? dq : 1'b1);
	// one slow rate for the whole run; stops low between frames
	initial
	begin
		sd_clk = 1'b0;
		#5;
		forever
		begin
			#32;
			if (run || sd_clk)
				sd_clk = ~sd_clk;
		end
	end
	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 39; i >= 0; i--)
			c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
		return c;
	endfunction : crc7
	// one frame out, any answer in; n stays 0 when none came
	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg,
		output logic [135:0] rsp, output int n);
		logic [47:0] f;
		f = {2'b01, idx, arg, 8'h01};
		f[7:1] = crc7(f[47:8]);
		rsp = '0;
		n = 0;
		run = 1'b1;
		for (int k = 47; k >= 0; k--)
		begin
			@(posedge sd_clk);
			dq <= f[k];
			drv <= 1'b1;
		end
		@(posedge sd_clk);
		drv <= 1'b0;
		for (int k = 0; k < 160; k++)
		begin
			@(negedge sd_clk);
			if (cmd_oe)
			begin
				rsp = {rsp[134:0], cmd_line};
				n++;
			end
			else if (n > 0 || k > 8)
				break;
		end
		repeat (16) @(posedge sd_clk);
		run = 1'b0;
	endtask : cmd
endmodule : sd_host_model

// [sim/testbench.sv]
`define chk(nm, e, g) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
		end \
	end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int pu_cycles = 4000;
	// identity value is arbitrary
	localparam logic [127:0] id_val = 128'h0123456789abcdef_fedcba9876543201;
	// status block content is arbitrary
	localparam logic [511:0] ext_val = {16{32'h5ec0_0d1e}};
	logic [511:0] ext_blk;
	logic mclk, rstn, sd_clk, cmd_line, cmd_out, cmd_oe, powerup_done;
	logic card_inactive;
	logic [3:0] card_state;
	logic [15:0] card_rca, card_dsr, r1;
	logic [135:0] rsp;
	logic [7:0] p;
	logic [8:0] w;
	logic [31:0] p32;
	int n, seed;
	int cyc = 0;
	int error_cnt = 0;
	int checks_done = 0;
	sd_card_init_identification #(
		.POWERUP_CYCLES(pu_cycles),
		.CARD_ID(id_val),
		.EXT_STATUS(ext_val)
	) sd_card_init_identification_i (
		.mclk(mclk),
		.rstn(rstn),
		.sd_clk(sd_clk),
		.cmd_in(cmd_line),
		.cmd_out(cmd_out),
		.cmd_oe(cmd_oe),
		.powerup_done(powerup_done),
		.card_state(card_state),
		.card_inactive(card_inactive),
		.card_rca(card_rca),
		.card_dsr(card_dsr),
		.ext_status_block(ext_blk)
	);
	sd_host_model sd_host_model_i (
		.sd_clk(sd_clk),
		.cmd_line(cmd_line),
		.cmd_out(cmd_out),
		.cmd_oe(cmd_oe)
	);
	function automatic logic [31:0] ocr_exp(input logic rdy, input logic c8);
		return {rdy, rdy & c8, 6'h00, 9'h1ff, 7'h00, c8, 7'h00};
	endfunction : ocr_exp
	function automatic logic [6:0] crc7_of(input logic [119:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 119; i >= 0; i--)
			c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
		return c;
	endfunction : crc7_of
	// identity as reported: reserved nibble clear, crc, stop bit
	function automatic logic [127:0] cid_exp(input logic [127:0] v);
		logic [119:0] b;
		b = {v[127:24], 4'h0, v[19:8]};
		return {b, crc7_of(b), 1'b1};
	endfunction : cid_exp
	task automatic send(input logic [5:0] idx, input logic [31:0] arg);
		sd_host_model_i.cmd(idx, arg, rsp, n);
	endtask : send
	task automatic acmd41(input logic hcs, input logic [8:0] win);
		send(6'h37, 32'h00000000);
		send(6'h29, {1'b0, hcs, 6'h00, win, 15'h0000});
	endtask : acmd41
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		mclk = 1'b0;
		forever
			#4 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	initial
	begin
		// start high so the link side surely sees a falling reset edge
		rstn = 1'b1;
		#1;
		rstn = 1'b0;
		seed = $urandom(32'h2b8f);
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		`chk("rca", 16'h0000, card_rca);
		`chk("dsr", 16'h0404, card_dsr);
		`chk("pu", 1'b0, powerup_done);
		`chk("ext", ext_val, ext_blk);
		p = 8'($urandom);
		w = 9'($urandom) | 9'h001;
		send(6'h08, {20'h0, 4'h1, p});
		`chk("echo", {20'h0, 4'h1, p}, rsp[39:8]);
		`chk("echo_crc", sd_host_model_i.crc7(rsp[47:8]), rsp[7:1]);
		acmd41(1'b1, w);
		`chk("busy", ocr_exp(1'b0, 1'b1), rsp[39:8]);
		// nothing but the poll pair is sent here
		for (int i = 0; i < 8 && rsp[39] !== 1'b1; i++)
			acmd41(1'b1, w);
		`chk("ready", ocr_exp(1'b1, 1'b1), rsp[39:8]);
		`chk("st_rdy", 4'h1, card_state);
		$display("test init finished");
		send(6'h02, 32'h00000000);
		`chk("cid_len", 136, n);
		`chk("cid", {id_val[127:24], 4'h0}, rsp[127:20]);
		`chk("cid_end", 1'b1, rsp[0]);
		`chk("cid_full", cid_exp(id_val), rsp[127:0]);
		`chk("st_id", 4'h2, card_state);
		send(6'h03, $urandom);
		r1 = rsp[39:24];
		`chk("rca_stat", 16'h0400, rsp[23:8]);
		`chk("rca_pub", 1'b1, r1 != 16'h0000);
		`chk("rca_act", r1, card_rca);
		`chk("st_sb", 4'h3, card_state);
		send(6'h03, $urandom);
		`chk("rca_new", 1'b1, rsp[39:24] != r1);
		`chk("rca_last", rsp[39:24], card_rca);
		send(6'h02, 32'h00000000);
		`chk("cid_stby", 0, n);
		p32 = $urandom;
		send(6'h04, p32);
		`chk("dsr_set", p32[31:16], card_dsr);
		$display("test ident finished");
		send(6'h00, 32'h00000000);
		`chk("rca_clr", 16'h0000, card_rca);
		send(6'h08, {20'h0, 4'h1, p});
		acmd41(1'b0, w);
		`chk("hcs0", ocr_exp(1'b0, 1'b1), rsp[39:8]);
		repeat (2)
		begin
			acmd41(1'b1, w);
			`chk("hcs_once", ocr_exp(1'b0, 1'b1), rsp[39:8]);
		end
		// no CMD8 answer, so the flag goes out clear
		send(6'h00, 32'h00000000);
		acmd41(1'b0, w);
		`chk("no_cmd8", ocr_exp(1'b0, 1'b0), rsp[39:8]);
		$display("test capacity finished");
		send(6'h00, 32'h00000000);
		acmd41(1'b0, 9'h000);
		`chk("inact_rsp", 0, n);
		`chk("inact", 1'b1, card_inactive);
		`chk("inact_st", 4'hf, card_state);
		send(6'h00, 32'h00000000);
		send(6'h08, {20'h0, 4'h1, p});
		`chk("inact_mute", 0, n);
		$display("test inactive finished");
		// only a reset leaves inactive; driver stage returns to default
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		`chk("rst_inact", 1'b0, card_inactive);
		`chk("rst_st", 4'h0, card_state);
		`chk("rst_dsr", 16'h0404, card_dsr);
		`chk("rst_rca", 16'h0000, card_rca);
		send(6'h08, {20'h0, 4'h1, p});
		`chk("rst_alive", 48, n);
		$display("test reset finished");
		wrap_up();
	end
endmodule : testbench
